// [flc_conv_model.sv]
// Behavioural conversion engine that answers the block's conversion requests
`timescale 1ns/1ns
module flc_conv_model
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Request from the block and result set by the bench
    input wire logic req_in,
    input wire logic [10:0] temp_in,
    input wire logic ool_in,
    // Result towards the block
    output logic done_out,
    output logic [10:0] temp_out,
    output logic ool_out
);
    logic [2:0] gap_q;
    logic go;
    assign go = req_in && (gap_q == 3'h7);
    // Result lines carry junk between results so stale data is never trusted
    always @(negedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            gap_q <= 3'h0;
            done_out <= 1'b0;
            temp_out <= 11'h000;
            ool_out <= 1'b0;
        end
        else
        begin
            gap_q <= req_in ? gap_q + 3'h1 : 3'h0;
            done_out <= go;
            temp_out <= go ? temp_in : ~temp_out;
            ool_out <= go ? ool_in : ~ool_out;
        end
    end
endmodule // flc_conv_model

// [flc_fault_queue.sv]
// Fault queue that qualifies out-of-limit conversion results into an event
`timescale 1ns/1ns
module flc_fault_queue
    import flc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Conversion results
    input wire logic done_in,
    input wire logic out_of_limit_in,
    input wire logic queue_en_in,
    // Qualified event level
    output logic event_out
);
    logic [1:0] count_q;
    logic [1:0] count_d;
    logic event_d;
    localparam logic [1:0] LAST_COUNT = 2'(FAULT_QUEUE_DEPTH - 1);

    wire bad = done_in && out_of_limit_in;
    wire good = done_in && !out_of_limit_in;
    wire qualified = bad && (!queue_en_in || count_q >= LAST_COUNT);

    // Counter saturates so a long run of faults keeps the event up
    assign count_d = good ? 2'b00 :
        (bad && count_q != LAST_COUNT) ? count_q + 2'b01 : count_q;
    assign event_d = qualified ? 1'b1 : (good ? 1'b0 : event_out);

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            count_q <= 2'b00;
            event_out <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            event_out <= event_d;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    fault_direct_a: assert property
        (bad && !queue_en_in |=> event_out)
        else $error("Single fault without queue raised no event");
    fault_early_a: assert property
        (queue_en_in && !event_out && done_in && count_q == 2'b00
         |=> !event_out)
        else $error("Queued fault raised event too early");
    fault_third_a: assert property
        (bad && queue_en_in && count_q == LAST_COUNT |=> event_out)
        else $error("Third consecutive fault raised no event");
    fault_clear_a: assert property
        (good |=> count_q == 2'b00 && !event_out)
        else $error("In-limit result did not clear fault count");
endmodule // flc_fault_queue

// [flc_lut_config.sv]
// Last fan table entry and main configuration register with their control logic
//
// Overview of operation
// - Low-resolution temperature mode holds threshold top bit at zero, reads zero.
// - High resolution uses eight threshold bits, half degrees; low uses seven.
// - Compare uses nine reading bits in high resolution, eight in low.
// - Reading above threshold drives the fan output with the entry duty.
// - Threshold is non-negative; sign bit assumed zero in every mode.
// - Table registers always readable; writable only while enable bit is set.
// - Low-resolution duty keeps bits 7:6 zero; high resolution forms eight bits.
// - Extended duty bits count only at the 22.5kHz output frequency.
// - Low-resolution duty takes six bits from duty bits 5:0.
// - Table temperature offset adds to the threshold for higher trip points.
// - Configuration register answers at two addresses sharing one storage.
// - Event mask one keeps open-drain event output released permanently.
// - Low-power bit stops continuous conversions and enters standby.
// - In standby a write to the one-shot address runs one conversion.
// - Fan-off-in-hold drives the inactive polarity level during standby.
// - Configuration bits 4:3 are reserved and read as zero.
// - Speed pulse input accepted only while its enable bit is one.
// - Unlock bit zero locks critical limit; one allows repeated rewrites.
// - Fault queue off: any out-of-limit result raises event; on: three.
`timescale 1ns/1ns
module flc_lut_config
    import flc_pkg::*;
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // Register access from the serial bus engine
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    output logic [7:0] REG_RDATA_OUT,
    // Mode settings held elsewhere in the device
    input wire logic TABLE_WRITE_EN_IN,
    input wire logic TEMP_HIRES_IN,
    input wire logic DUTY_HIRES_IN,
    input wire logic FREQ_22K5_IN,
    input wire logic PWM_ACTIVE_HIGH_IN,
    input wire logic [7:0] TABLE_OFFSET_IN,
    // Conversion engine
    input wire logic [10:0] REMOTE_TEMP_IN,
    input wire logic CONV_DONE_IN,
    input wire logic OUT_OF_LIMIT_IN,
    output logic CONV_REQ_OUT,
    output logic LOW_POWER_OUT,
    // Fan control
    input wire logic PWM_RAW_IN,
    output logic ENTRY12_HIT_OUT,
    output logic [7:0] FAN_DUTY_OUT,
    output logic FAN_PWM_OUT,
    // Speed pulse pin
    input wire logic SPEED_PIN_IN,
    output logic SPEED_PULSE_OUT,
    // Critical limit lock
    output logic CRIT_LIMIT_UNLOCK_OUT,
    // Open-drain event pin, driven low while enabled
    output logic EVENT_O_OUT,
    output logic EVENT_OE_OUT
);
    import flc_pkg::*;

    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [7:0] thr_q;
    logic [7:0] thr_d;
    logic [7:0] duty_q;
    logic [7:0] duty_d;
    flc_conv_state_t state_q;
    flc_conv_state_t state_d;
    logic [7:0] rdata_d;
    logic speed_level;
    logic fault_event;

    // Address decode
    wire cfg_sel = (REG_ADDR_IN == CFG_ADDR) ||
        (REG_ADDR_IN == CFG_ALIAS_ADDR);
    wire thr_sel = (REG_ADDR_IN == THR12_ADDR);
    wire duty_sel = (REG_ADDR_IN == DUTY12_ADDR);
    wire shot_sel = (REG_ADDR_IN == ONE_SHOT_ADDR);
    wire cfg_wr = REG_WR_IN && cfg_sel;
    wire thr_wr = REG_WR_IN && thr_sel && TABLE_WRITE_EN_IN;
    wire duty_wr = REG_WR_IN && duty_sel && TABLE_WRITE_EN_IN;
    wire shot_wr = REG_WR_IN && shot_sel;

    // Configuration fields
    wire event_output_mask = cfg_q[EVENT_MASK_BIT];
    wire low_power_hold = cfg_q[LOW_POWER_BIT];
    wire fan_output_off_in_hold = cfg_q[FAN_OFF_HOLD_BIT];
    wire speed_pulse_input_enable = cfg_q[SPEED_EN_BIT];
    wire critical_limit_unlock = cfg_q[CRIT_UNLOCK_BIT];
    wire fault_queue_enable = cfg_q[FAULT_QUEUE_BIT];

    // Reserved bits never store, so they read back as zero
    assign cfg_d = cfg_wr ? (REG_WDATA_IN & CFG_WRITABLE) : cfg_q;

    // Top threshold bit is cleared whenever low resolution is selected
    wire [7:0] thr_new = thr_wr ? REG_WDATA_IN : thr_q;
    assign thr_d = {thr_new[THR_HALF_BIT] & TEMP_HIRES_IN,
        thr_new[6:0]};

    // Extension bits are cleared whenever low-resolution duty is selected
    wire [7:0] duty_new = duty_wr ? REG_WDATA_IN : duty_q;
    assign duty_d = {duty_new[DUTY_EXT_MSB:DUTY_EXT_LSB] &
        {2{DUTY_HIRES_IN}}, duty_new[5:0]};

    // Threshold and duty fields
    wire entry12_threshold_half_bit = thr_q[THR_HALF_BIT];
    wire [6:0] entry12_threshold_value = thr_q[6:0];
    wire [1:0] entry12_duty_extension = duty_q[DUTY_EXT_MSB:DUTY_EXT_LSB];
    wire [5:0] entry12_duty_value = duty_q[5:0];

    // Everything compares in half-degree units; threshold has no sign bit
    wire [7:0] thr_half = TEMP_HIRES_IN ?
        {entry12_threshold_value, entry12_threshold_half_bit} :
        {entry12_threshold_value, 1'b0};
    wire [9:0] thr_eff = {1'b0, TABLE_OFFSET_IN, 1'b0} +
        {2'b00, thr_half};
    // Reading is 1/8 degree; low resolution drops the half-degree bit
    wire [8:0] temp_half = TEMP_HIRES_IN ? REMOTE_TEMP_IN[10:2] :
        {REMOTE_TEMP_IN[10:3], 1'b0};
    wire temp_above = {1'b0, temp_half} > thr_eff;

    // Extended duty bits only count at the 22.5kHz output rate
    wire use_ext = DUTY_HIRES_IN && FREQ_22K5_IN;
    wire [7:0] duty_eff = use_ext ?
        {entry12_duty_extension, entry12_duty_value} :
        {2'b00, entry12_duty_value};

    // Conversion control: one-shot only means something in standby
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            CONV_IDLE:
                if (!low_power_hold)
                    state_d = CONV_RUN;
                else if (shot_wr)
                    state_d = CONV_SHOT;
            CONV_RUN:
                if (low_power_hold)
                    state_d = CONV_IDLE;
            CONV_SHOT:
                if (CONV_DONE_IN)
                    state_d = low_power_hold ? CONV_IDLE : CONV_RUN;
            default:
                state_d = CONV_IDLE;
        endcase
    end

    // Read multiplexer; unmapped addresses answer a fixed value
    assign rdata_d = cfg_sel ? cfg_q :
        thr_sel ? {thr_q[THR_HALF_BIT] & TEMP_HIRES_IN, thr_q[6:0]} :
        duty_sel ? duty_q : UNMAPPED_READ;

    // Fan level during standby with the off bit set is the inactive level
    wire fan_forced = LOW_POWER_OUT && fan_output_off_in_hold;
    wire fan_level = fan_forced ? !PWM_ACTIVE_HIGH_IN : PWM_RAW_IN;

    flc_pin_sync speed_sync
    (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .pin_in(SPEED_PIN_IN),
        .level_out(speed_level)
    );

    flc_fault_queue fault_queue
    (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .done_in(CONV_DONE_IN),
        .out_of_limit_in(OUT_OF_LIMIT_IN),
        .queue_en_in(fault_queue_enable),
        .event_out(fault_event)
    );

    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            cfg_q <= CFG_RESET;
            thr_q <= THR12_RESET;
            duty_q <= DUTY12_RESET;
            state_q <= CONV_IDLE;
            REG_RDATA_OUT <= UNMAPPED_READ;
        end
        else
        begin
            cfg_q <= cfg_d;
            thr_q <= thr_d;
            duty_q <= duty_d;
            state_q <= state_d;
            REG_RDATA_OUT <= rdata_d;
        end
    end

    // Comparison results update only when a conversion finishes
    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            ENTRY12_HIT_OUT <= 1'b0;
            FAN_DUTY_OUT <= 8'h00;
        end
        else if (CONV_DONE_IN)
        begin
            ENTRY12_HIT_OUT <= temp_above;
            if (temp_above)
            begin
                FAN_DUTY_OUT <= duty_eff;
            end
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            CONV_REQ_OUT <= 1'b0;
            LOW_POWER_OUT <= 1'b0;
            FAN_PWM_OUT <= 1'b0;
            SPEED_PULSE_OUT <= 1'b0;
            CRIT_LIMIT_UNLOCK_OUT <= 1'b0;
            EVENT_O_OUT <= 1'b0;
            EVENT_OE_OUT <= 1'b0;
        end
        else
        begin
            CONV_REQ_OUT <= (state_d != CONV_IDLE);
            LOW_POWER_OUT <= (state_d == CONV_IDLE);
            FAN_PWM_OUT <= fan_level;
            SPEED_PULSE_OUT <= speed_level && speed_pulse_input_enable;
            CRIT_LIMIT_UNLOCK_OUT <= critical_limit_unlock;
            EVENT_O_OUT <= 1'b0;
            EVENT_OE_OUT <= fault_event && !event_output_mask;
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    sequence shot_request_s;
        state_q == CONV_IDLE && low_power_hold && !cfg_wr && shot_wr;
    endsequence
    sequence shot_running_s;
        CONV_REQ_OUT && state_q == CONV_SHOT;
    endsequence

    cfg_alias_a: assert property
        (REG_WR_IN && REG_ADDR_IN == CFG_ALIAS_ADDR
         |=> cfg_q == ($past(REG_WDATA_IN) & CFG_WRITABLE))
        else $error("Alias write did not reach configuration");
    table_lock_a: assert property
        (REG_WR_IN && (thr_sel || duty_sel) && !TABLE_WRITE_EN_IN
         && TEMP_HIRES_IN && DUTY_HIRES_IN |=> $stable(thr_q) && $stable(duty_q))
        else $error("Table entry changed while writes disabled");
    thr_low_a: assert property (!TEMP_HIRES_IN |=> !thr_q[THR_HALF_BIT])
        else $error("Threshold top bit set in low resolution");
    duty_low_a: assert property (!DUTY_HIRES_IN |=> duty_q[7:6] == 2'b00)
        else $error("Duty extension set in low resolution");
    duty_drive_a: assert property
        (CONV_DONE_IN && temp_above |=> ENTRY12_HIT_OUT &&
         FAN_DUTY_OUT == $past(duty_eff))
        else $error("Fan duty not taken from entry above threshold");
    ext_ignored_a: assert property
        (CONV_DONE_IN && temp_above && !FREQ_22K5_IN
         |=> FAN_DUTY_OUT[7:6] == 2'b00)
        else $error("Extended duty used outside 22.5kHz");
    reserved_read_a: assert property (cfg_sel |=> REG_RDATA_OUT[4:3] == 2'b00)
        else $error("Reserved configuration bits read nonzero");
    event_mask_a: assert property (event_output_mask |=> !EVENT_OE_OUT)
        else $error("Masked event output was driven");
    standby_stop_a: assert property
        (low_power_hold && state_q == CONV_IDLE && !shot_wr |=> !CONV_REQ_OUT)
        else $error("Conversion requested in standby");
    one_shot_a: assert property
        (shot_running_s and (CONV_DONE_IN && low_power_hold)
         |=> !CONV_REQ_OUT && LOW_POWER_OUT)
        else $error("One-shot ran more than one conversion");
    shot_start_a: assert property (shot_request_s |=> shot_running_s)
        else $error("One-shot write started no conversion");
    fan_off_a: assert property
        (fan_forced |=> FAN_PWM_OUT == !$past(PWM_ACTIVE_HIGH_IN))
        else $error("Fan output not inactive in standby");
    speed_off_a: assert property (!speed_pulse_input_enable |=> !SPEED_PULSE_OUT)
        else $error("Speed input passed while disabled");
endmodule // flc_lut_config

// [flc_pin_sync.sv]
// Three-stage pin synchroniser that accepts a change when stages two and three agree
`timescale 1ns/1ns
module flc_pin_sync
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Pin and clean level
    input wire logic pin_in,
    output logic level_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    wire agree = (s2_q == s3_q);

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_out <= 1'b0;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree)
            begin
                level_out <= s3_q;
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sync_agree_a: assert property ($changed(level_out) |-> $past(agree))
        else $error("Clean level changed without agreeing stages");
endmodule // flc_pin_sync

// [flc_pkg.sv]
// Package of register map, field positions and reset values for the fan table block
package flc_pkg;

    // Register addresses
    localparam logic [7:0] CFG_ADDR = 8'h03;
    localparam logic [7:0] CFG_ALIAS_ADDR = 8'h09;
    localparam logic [7:0] ONE_SHOT_ADDR = 8'h0f;
    localparam logic [7:0] THR12_ADDR = 8'h66;
    localparam logic [7:0] DUTY12_ADDR = 8'h67;

    // Reset values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] THR12_RESET = 8'h7f;
    localparam logic [7:0] DUTY12_RESET = 8'h3f;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Configuration field positions
    localparam int EVENT_MASK_BIT = 7;
    localparam int LOW_POWER_BIT = 6;
    localparam int FAN_OFF_HOLD_BIT = 5;
    localparam int SPEED_EN_BIT = 2;
    localparam int CRIT_UNLOCK_BIT = 1;
    localparam int FAULT_QUEUE_BIT = 0;
    // Bits that store; reserved bits 4:3 never store and read as zero
    localparam logic [7:0] CFG_WRITABLE = 8'he7;

    // Table entry field positions
    localparam int THR_HALF_BIT = 7;
    localparam int DUTY_EXT_MSB = 7;
    localparam int DUTY_EXT_LSB = 6;

    // Consecutive out-of-limit results needed with the fault queue on
    localparam int FAULT_QUEUE_DEPTH = 3;

    // Conversion control states, Gray coded along idle, run, one-shot
    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_RUN = 2'b01,
        CONV_SHOT = 2'b11
    } flc_conv_state_t;

endpackage : flc_pkg

// [tb.sv]
// Self-checking bench for the last fan table entry and configuration register
`timescale 1ns/1ns
module tb;
    import flc_pkg::*;
    logic CLK_IN = 1'b0;
    logic RST_IN = 1'b1;
    logic [7:0] REG_ADDR_IN = 8'h00;
    logic [7:0] REG_WDATA_IN = 8'h00;
    logic REG_WR_IN = 1'b0;
    logic [7:0] REG_RDATA_OUT;
    logic TABLE_WRITE_EN_IN = 1'b0;
    logic TEMP_HIRES_IN = 1'b1;
    logic DUTY_HIRES_IN = 1'b1;
    logic FREQ_22K5_IN = 1'b1;
    logic PWM_ACTIVE_HIGH_IN = 1'b1;
    logic [7:0] TABLE_OFFSET_IN = 8'h00;
    logic [10:0] REMOTE_TEMP_IN;
    logic CONV_DONE_IN;
    logic OUT_OF_LIMIT_IN;
    logic CONV_REQ_OUT, LOW_POWER_OUT, PWM_RAW_IN = 1'b0;
    logic ENTRY12_HIT_OUT, FAN_PWM_OUT, SPEED_PIN_IN = 1'b0;
    logic [7:0] FAN_DUTY_OUT;
    logic SPEED_PULSE_OUT, CRIT_LIMIT_UNLOCK_OUT, EVENT_O_OUT, EVENT_OE_OUT;
    logic [10:0] t_temp = 11'h000;
    logic t_ool = 1'b0;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;

    always #5 CLK_IN = ~CLK_IN;

    flc_lut_config DUT (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
        .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
        .REG_WR_IN(REG_WR_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
        .TABLE_WRITE_EN_IN(TABLE_WRITE_EN_IN), .TEMP_HIRES_IN(TEMP_HIRES_IN),
        .DUTY_HIRES_IN(DUTY_HIRES_IN), .FREQ_22K5_IN(FREQ_22K5_IN),
        .PWM_ACTIVE_HIGH_IN(PWM_ACTIVE_HIGH_IN),
        .TABLE_OFFSET_IN(TABLE_OFFSET_IN), .REMOTE_TEMP_IN(REMOTE_TEMP_IN),
        .CONV_DONE_IN(CONV_DONE_IN), .OUT_OF_LIMIT_IN(OUT_OF_LIMIT_IN),
        .CONV_REQ_OUT(CONV_REQ_OUT), .LOW_POWER_OUT(LOW_POWER_OUT),
        .PWM_RAW_IN(PWM_RAW_IN), .ENTRY12_HIT_OUT(ENTRY12_HIT_OUT),
        .FAN_DUTY_OUT(FAN_DUTY_OUT), .FAN_PWM_OUT(FAN_PWM_OUT),
        .SPEED_PIN_IN(SPEED_PIN_IN), .SPEED_PULSE_OUT(SPEED_PULSE_OUT),
        .CRIT_LIMIT_UNLOCK_OUT(CRIT_LIMIT_UNLOCK_OUT),
        .EVENT_O_OUT(EVENT_O_OUT), .EVENT_OE_OUT(EVENT_OE_OUT));

    flc_conv_model conv_model (.clk_in(CLK_IN), .rst_in(RST_IN),
        .req_in(CONV_REQ_OUT), .temp_in(t_temp), .ool_in(t_ool),
        .done_out(CONV_DONE_IN), .temp_out(REMOTE_TEMP_IN),
        .ool_out(OUT_OF_LIMIT_IN));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK_IN);
        REG_ADDR_IN = a;
        REG_WDATA_IN = d;
        REG_WR_IN = 1'b1;
        @(negedge CLK_IN);
        REG_WR_IN = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge CLK_IN);
        REG_ADDR_IN = a;
        @(negedge CLK_IN);
        chk("read data", exp, REG_RDATA_OUT);
    endtask

    // Skips a result already under way so the one awaited carries new data
    task automatic conv(input logic [10:0] tmp, input logic ool);
        int k;
        k = 0;
        @(negedge CLK_IN);
        t_temp <= tmp;
        t_ool <= ool;
        @(posedge CLK_IN);
        do
        begin
            @(posedge CLK_IN);
            k++;
        end
        while (CONV_DONE_IN !== 1'b1 && k < 40);
        if (k >= 40)
            chk("done", 8'h01, 8'h00);
        @(negedge CLK_IN);
    endtask

    task automatic lut_case(input logic th, dh, fk, input logic [7:0] off,
        input logic [7:0] thr, dty, input logic [10:0] tmp,
        input logic hit, input logic [7:0] fd);
        @(negedge CLK_IN);
        TEMP_HIRES_IN = th;
        DUTY_HIRES_IN = dh;
        FREQ_22K5_IN = fk;
        TABLE_OFFSET_IN = off;
        wr(THR12_ADDR, thr);
        wr(DUTY12_ADDR, dty);
        conv(tmp, 1'b0);
        chk("hit", {7'h00, hit}, {7'h00, ENTRY12_HIT_OUT});
        chk("fan duty", fd, FAN_DUTY_OUT);
    endtask

    task automatic ev(input logic [10:0] tmp, input logic ool, input logic e);
        conv(tmp, ool);
        @(negedge CLK_IN);
        chk("event", {7'h00, e}, {7'h00, EVENT_OE_OUT});
    endtask

    always @(posedge CLK_IN)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (16) @(negedge CLK_IN);
        RST_IN = 1'b0;
        rd(CFG_ADDR, 8'h00);
        rd(THR12_ADDR, 8'h7f);
        rd(DUTY12_ADDR, 8'h3f);
        rd(8'h20, 8'h00);
        $display("test reset done");
        wr(THR12_ADDR, 8'h12);
        rd(THR12_ADDR, 8'h7f);
        TABLE_WRITE_EN_IN = 1'b1;
        wr(THR12_ADDR, 8'h92);
        rd(THR12_ADDR, 8'h92);
        TEMP_HIRES_IN = 1'b0;
        DUTY_HIRES_IN = 1'b0;
        wr(THR12_ADDR, 8'hff);
        rd(THR12_ADDR, 8'h7f);
        wr(DUTY12_ADDR, 8'hff);
        rd(DUTY12_ADDR, 8'h3f);
        $display("test table access done");
        lut_case(1, 1, 1, 8'h00, 8'h32, 8'hc5, 11'h194, 1, 8'hc5);
        lut_case(1, 1, 1, 8'h00, 8'hb2, 8'hc5, 11'h194, 0, 8'hc5);
        lut_case(0, 1, 1, 8'h00, 8'h32, 8'hc5, 11'h194, 0, 8'hc5);
        lut_case(0, 1, 0, 8'h00, 8'h32, 8'hc5, 11'h198, 1, 8'h05);
        lut_case(0, 0, 1, 8'h00, 8'h32, 8'hca, 11'h198, 1, 8'h0a);
        lut_case(1, 1, 1, 8'h0a, 8'h32, 8'h80, 11'h1b8, 0, 8'h0a);
        lut_case(1, 1, 1, 8'h0a, 8'h32, 8'h80, 11'h1e8, 1, 8'h80);
        lut_case(1, 1, 1, 8'h00, 8'hff, 8'h7f, 11'h400, 1, 8'h7f);
        $display("test table compare done");
        ev(11'h100, 1'b1, 1'b1);
        ev(11'h100, 1'b0, 1'b0);
        wr(CFG_ADDR, 8'h01);
        ev(11'h100, 1'b1, 1'b0);
        ev(11'h100, 1'b1, 1'b0);
        ev(11'h100, 1'b1, 1'b1);
        ev(11'h100, 1'b0, 1'b0);
        ev(11'h100, 1'b1, 1'b0);
        ev(11'h100, 1'b1, 1'b0);
        wr(CFG_ALIAS_ADDR, 8'h80);
        ev(11'h100, 1'b1, 1'b0);
        ev(11'h100, 1'b1, 1'b0);
        chk("event level", 8'h00, {7'h00, EVENT_O_OUT});
        $display("test fault queue done");
        wr(CFG_ALIAS_ADDR, 8'hff);
        rd(CFG_ADDR, 8'he7);
        chk("unlock", 8'h01, {7'h00, CRIT_LIMIT_UNLOCK_OUT});
        SPEED_PIN_IN = 1'b1;
        PWM_RAW_IN = 1'b1;
        repeat (8) @(negedge CLK_IN);
        chk("speed", 8'h01, {7'h00, SPEED_PULSE_OUT});
        chk("request", 8'h00, {7'h00, CONV_REQ_OUT});
        chk("standby", 8'h01, {7'h00, LOW_POWER_OUT});
        chk("fan pin", 8'h00, {7'h00, FAN_PWM_OUT});
        PWM_ACTIVE_HIGH_IN = 1'b0;
        PWM_RAW_IN = 1'b0;
        repeat (3) @(negedge CLK_IN);
        chk("fan pin", 8'h01, {7'h00, FAN_PWM_OUT});
        wr(CFG_ADDR, 8'h40);
        rd(CFG_ALIAS_ADDR, 8'h40);
        repeat (8) @(negedge CLK_IN);
        chk("speed", 8'h00, {7'h00, SPEED_PULSE_OUT});
        chk("unlock", 8'h00, {7'h00, CRIT_LIMIT_UNLOCK_OUT});
        chk("fan pin", 8'h00, {7'h00, FAN_PWM_OUT});
        $display("test configuration done");
        wr(ONE_SHOT_ADDR, 8'h5a);
        chk("request", 8'h01, {7'h00, CONV_REQ_OUT});
        // Reading well above the stored 0xff threshold so the result shows
        conv(11'h7ff, 1'b0);
        chk("request", 8'h00, {7'h00, CONV_REQ_OUT});
        chk("standby", 8'h01, {7'h00, LOW_POWER_OUT});
        chk("hit", 8'h01, {7'h00, ENTRY12_HIT_OUT});
        chk("fan duty", 8'h7f, FAN_DUTY_OUT);
        repeat (20) @(negedge CLK_IN);
        chk("request", 8'h00, {7'h00, CONV_REQ_OUT});
        wr(CFG_ADDR, 8'h00);
        @(negedge CLK_IN);
        chk("request", 8'h01, {7'h00, CONV_REQ_OUT});
        $display("test one shot done");
        wrap_up();
    end
endmodule // tb
